// ### verilog/sff_pkg.sv
// Shared constants for the serial field FIFO: widths, depth, pass limits.
// Assumes nothing beyond a SystemVerilog compiler; imported by every module.
// Operation
// - Staged last byte reaches storage only on a following write clock, e.g. the clear.
// - Write timing lags read timing by one clock, easing chaining.
// - First write clock edge seeing clear high zeroes the write pointer.
// - Write enable and write mask are ignored in the clearing cycle.
// - Each write edge with enable high captures a byte and advances pointer.
// - Write enable low: no capture, write pointer holds.
// - No limit on how long write enable stays high or low.
// - Mask high writes the byte; mask low keeps memory, pointer still advances.
// - First read clock edge seeing clear high zeroes the read pointer.
// - Step gate and drive enable are ignored in the read clearing cycle.
// - Only the step gate stops read advance; mask and drive enable never do.
// - Write and read clocks are independent and may stop indefinitely.
// - Storage needs no refresh commands from outside.
// - Capacity is 256K locations of eight bits.
// - First word moves on the first clock after a clear, no latency.
// - Each read edge with step gate high presents next byte, advances pointer.
// - Drive enable high drives output bus; low floats it, pointer still advances.
package sff_pkg;
    localparam int          DATA_W     = 8;       // Byte width
    localparam int          ADDR_W     = 18;      // Pointer width for 256K locations
    localparam int          DEPTH      = 262144;  // Locations in the store
    localparam int          PASS_W     = 7;       // Width of the active-cycle counter
    localparam logic [6:0]  MIN_ACTIVE = 7'h50;   // Least active cycles per pass (80)
endpackage

// ### verilog/sff_mem_if.sv
// Carrier between the write port, the read port and the system-clock logic.
// Assumes the storage lives with the write port and is read asynchronously.
interface sff_mem_if;
    import sff_pkg::*;
    logic [ADDR_W-1:0] rd_addr;       // Read pointer into the store
    logic [DATA_W-1:0] rd_data;       // Byte at rd_addr
    logic              wr_short_tgl;  // Toggles on a short write pass
    logic              rd_short_tgl;  // Toggles on a short read pass

    modport wr  (input rd_addr, output rd_data, output wr_short_tgl);
    modport rd  (output rd_addr, input rd_data, output rd_short_tgl);
    modport sys (input wr_short_tgl, input rd_short_tgl);
endinterface

// ### verilog/sff_wr_port.sv
// Write port: pointer, one-stage staging register and the flop storage array.
// Assumes write pins are synchronous to wclk; resetn is sampled into wclk here.
module sff_wr_port import sff_pkg::*; #(
    parameter int DEPTH_P = DEPTH             // Locations held
) (
    input  wire logic              wclk,      // Write shift clock
    input  wire logic              resetn,    // System reset, async to wclk
    input  wire logic              wr_clear,  // Write pointer clear
    input  wire logic              wr_enable, // Write enable
    input  wire logic              wr_mask,   // Input write mask
    input  wire logic [DATA_W-1:0] wr_data,   // Input byte bus
    sff_mem_if.wr                  mem        // Storage read side and events
);
    logic                rst_meta;
    logic                rst_sync;
    logic [ADDR_W-1:0]   wr_ptr;
    logic                pend_vld;
    logic                pend_mask;
    logic [ADDR_W-1:0]   pend_addr;
    logic [DATA_W-1:0]   pend_data;
    logic [PASS_W-1:0]   pass_cnt;
    logic                seen_clear;
    logic                short_tgl;
    logic [DATA_W-1:0]   store [DEPTH_P];  // Static flops: no refresh needed

    wire port_rst   = !rst_sync;
    wire take_byte  = !wr_clear && wr_enable;
    wire pass_short = seen_clear && (pass_cnt < MIN_ACTIVE);

    // Reset sampled in the write domain; wclk may stop, so no async path
    always_ff @(posedge wclk) begin
        rst_meta <= resetn;
        rst_sync <= rst_meta;
    end

    // Pointer and staging; the store is written one edge after capture
    always_ff @(posedge wclk) begin
        if (port_rst) begin
            wr_ptr   <= '0;
            pend_vld <= 1'b0;
        end else if (wr_clear) begin
            wr_ptr   <= '0;
            pend_vld <= 1'b0;
        end else if (take_byte) begin
            wr_ptr    <= wr_ptr + 1'b1;
            pend_vld  <= 1'b1;
            pend_mask <= wr_mask;
            pend_addr <= wr_ptr;
            pend_data <= wr_data;
        end else begin
            pend_vld <= 1'b0;
        end
    end

    // Commit of staged byte; on a clear edge this flushes the last one
    always_ff @(posedge wclk) begin
        if (pend_vld && pend_mask) begin
            store[pend_addr] <= pend_data;
        end
    end

    // Active-cycle count per pass; a short pass raises an event
    always_ff @(posedge wclk) begin
        if (port_rst) begin
            pass_cnt   <= '0;
            seen_clear <= 1'b0;
            short_tgl  <= 1'b0;
        end else if (wr_clear) begin
            pass_cnt   <= '0;
            seen_clear <= 1'b1;
            if (pass_short) begin
                short_tgl <= !short_tgl;
            end
        end else if (wr_enable && pass_cnt < MIN_ACTIVE) begin
            pass_cnt <= pass_cnt + 1'b1;
        end
    end

    // Asynchronous read of the store; reader waits out the clear spacing
    assign mem.rd_data      = store[mem.rd_addr];
    assign mem.wr_short_tgl = short_tgl;

    a_wr_clear_zero: assert property (@(posedge wclk) disable iff (port_rst)
        wr_clear |=> wr_ptr == '0) else $error("write pointer not zero after clear");
    a_wr_hold_idle: assert property (@(posedge wclk) disable iff (port_rst)
        !wr_clear && !wr_enable |=> $stable(wr_ptr)) else $error("write pointer moved while idle");
    a_wr_step_one: assert property (@(posedge wclk) disable iff (port_rst)
        take_byte |=> wr_ptr == ADDR_W'($past(wr_ptr) + 1'b1)) else $error("write pointer step wrong");
    a_wr_late_commit: assert property (@(posedge wclk) disable iff (port_rst)
        take_byte && wr_mask ##1 1'b1 |=> store[$past(wr_ptr, 2)] == $past(wr_data, 2))
        else $error("byte not stored one clock late");
    a_wr_mask_keep: assert property (@(posedge wclk) disable iff (port_rst)
        take_byte && !wr_mask |=> !(pend_vld && pend_mask)) else $error("masked byte would be stored");
endmodule // sff_wr_port

// ### verilog/sff_rd_port.sv
// Read port: read pointer, output byte register and output drive enable.
// Assumes read pins are synchronous to rclk; resetn is sampled into rclk here.
module sff_rd_port import sff_pkg::*; (
    input  wire logic              rclk,      // Outbound shift clock
    input  wire logic              resetn,    // System reset, async to rclk
    input  wire logic              rd_clear,  // Outbound pointer clear
    input  wire logic              rd_step,   // Outbound step gate
    input  wire logic              rd_drive,  // Output drive enable
    output logic      [DATA_W-1:0] rd_out,    // Output byte bus
    output logic                   rd_oe,     // High while bus is driven
    sff_mem_if.rd                  mem        // Storage read side and events
);
    logic                rst_meta;
    logic                rst_sync;
    logic [ADDR_W-1:0]   rd_ptr;
    logic [PASS_W-1:0]   pass_cnt;
    logic                seen_clear;
    logic                short_tgl;

    wire port_rst   = !rst_sync;
    wire take_step  = !rd_clear && rd_step;
    wire pass_short = seen_clear && (pass_cnt < MIN_ACTIVE);

    // Reset sampled in the read domain
    always_ff @(posedge rclk) begin
        rst_meta <= resetn;
        rst_sync <= rst_meta;
    end

    // Word 0 leaves on the first gated edge after a clear
    always_ff @(posedge rclk) begin
        if (port_rst) begin
            rd_ptr <= '0;
            rd_out <= '0;
            rd_oe  <= 1'b0;
        end else if (rd_clear) begin
            rd_ptr <= '0;
        end else begin
            rd_oe <= rd_drive;
            if (rd_step) begin
                rd_out <= mem.rd_data;
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Active-cycle count per read pass
    always_ff @(posedge rclk) begin
        if (port_rst) begin
            pass_cnt   <= '0;
            seen_clear <= 1'b0;
            short_tgl  <= 1'b0;
        end else if (rd_clear) begin
            pass_cnt   <= '0;
            seen_clear <= 1'b1;
            if (pass_short) begin
                short_tgl <= !short_tgl;
            end
        end else if (rd_step && pass_cnt < MIN_ACTIVE) begin
            pass_cnt <= pass_cnt + 1'b1;
        end
    end

    assign mem.rd_addr      = rd_ptr;
    assign mem.rd_short_tgl = short_tgl;

    a_rd_clear_zero: assert property (@(posedge rclk) disable iff (port_rst)
        rd_clear |=> rd_ptr == '0 && $stable(rd_oe)) else $error("read clear misbehaved");
    a_rd_hold_gate: assert property (@(posedge rclk) disable iff (port_rst)
        !rd_clear && !rd_step |=> $stable(rd_ptr) && $stable(rd_out))
        else $error("read moved with gate low");
    a_rd_next_byte: assert property (@(posedge rclk) disable iff (port_rst)
        take_step |=> rd_out == $past(mem.rd_data) && rd_ptr == ADDR_W'($past(rd_ptr) + 1'b1))
        else $error("read byte or step wrong");
    a_rd_drive_free: assert property (@(posedge rclk) disable iff (port_rst)
        take_step && !rd_drive |=> !rd_oe && rd_ptr != $past(rd_ptr))
        else $error("drive enable stopped pointer");
endmodule // sff_rd_port

// ### verilog/sff_top.sv
// Serial field FIFO top: write and read ports plus system-clock status flags.
// Assumes write and read pins are timed to their own shift clocks.
module sff_top import sff_pkg::*; (
    input  wire logic              clk_sys,                // System clock, 125 MHz
    input  wire logic              resetn,                 // Async reset, active low
    input  wire logic              write_shift_clock,      // Write port clock
    input  wire logic              write_pointer_clear,    // Write pointer clear
    input  wire logic              write_enable,           // Write enable
    input  wire logic              input_write_mask,       // Write mask, high writes
    input  wire logic [DATA_W-1:0] input_byte_bus,         // Input byte
    input  wire logic              outbound_shift_clock,   // Read port clock
    input  wire logic              outbound_pointer_clear, // Read pointer clear
    input  wire logic              outbound_step_gate,     // Read step gate
    input  wire logic              output_drive_enable,    // Output drive enable
    output logic      [DATA_W-1:0] output_byte_bus,        // Output byte
    output logic                   output_byte_oe,         // High while bus driven
    output logic                   write_pass_short,       // Sticky: short write pass
    output logic                   read_pass_short         // Sticky: short read pass
);
    sff_mem_if mem ();

    logic [2:0] wr_evt_sync;
    logic [2:0] rd_evt_sync;

    // Ports run free of each other; only the store and toggles link them
    sff_wr_port u_wr (
        .wclk      (write_shift_clock),
        .resetn    (resetn),
        .wr_clear  (write_pointer_clear),
        .wr_enable (write_enable),
        .wr_mask   (input_write_mask),
        .wr_data   (input_byte_bus),
        .mem       (mem.wr)
    );

    sff_rd_port u_rd (
        .rclk      (outbound_shift_clock),
        .resetn    (resetn),
        .rd_clear  (outbound_pointer_clear),
        .rd_step   (outbound_step_gate),
        .rd_drive  (output_drive_enable),
        .rd_out    (output_byte_bus),
        .rd_oe     (output_byte_oe),
        .mem       (mem.rd)
    );

    // Toggle events crossed in by two flops; third flop only for edge detect
    wire wr_evt = wr_evt_sync[1] ^ wr_evt_sync[2];
    wire rd_evt = rd_evt_sync[1] ^ rd_evt_sync[2];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_evt_sync <= 3'h0;
            rd_evt_sync <= 3'h0;
        end else begin
            wr_evt_sync <= {wr_evt_sync[1:0], mem.wr_short_tgl};
            rd_evt_sync <= {rd_evt_sync[1:0], mem.rd_short_tgl};
        end
    end

    // Sticky diagnostics of passes the host kept too short
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            write_pass_short <= 1'b0;
            read_pass_short  <= 1'b0;
        end else begin
            write_pass_short <= write_pass_short | wr_evt;
            read_pass_short  <= read_pass_short | rd_evt;
        end
    end

    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
        write_pass_short |=> write_pass_short) else $error("write short flag dropped");
    a_flag_rise: assert property (@(posedge clk_sys) disable iff (!resetn)
        rd_evt |=> read_pass_short) else $error("read short event lost");
endmodule // sff_top

// ### tb/sff_video_model.sv
// Video-side partner: drives the write and read ports of the field FIFO.
// Assumes the bench calls its tasks; both shift clocks stand still between calls.
module sff_video_model import sff_pkg::*; (
    output logic              wclk,     // Write shift clock
    output logic              wr_clear, // Write pointer clear
    output logic              wr_en,    // Write enable
    output logic              wr_mask,  // Input write mask
    output logic [DATA_W-1:0] wr_data,  // Input byte
    output logic              rclk,     // Outbound shift clock
    output logic              rd_clear, // Outbound pointer clear
    output logic              rd_step,  // Outbound step gate
    output logic              rd_drive  // Output drive enable
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle low; clocks only toggle inside a cycle task
    initial begin
        {wclk, wr_clear, wr_en, wr_mask, rclk, rd_clear, rd_step, rd_drive} = '0;
        wr_data = 8'h00;
    end
    // 6 ns write cycle; pins held half a period either side of the edge
    task automatic wr_cycle(input logic clr, input logic en, input logic msk, input logic [DATA_W-1:0] d);
        wr_clear = clr;
        wr_en    = en;
        wr_mask  = msk;
        wr_data  = en ? d : ~wr_data; // Unused bus keeps moving
        #3 wclk = 1'b1;
        #3 wclk = 1'b0;
    endtask
    // 6 ns read cycle, same discipline as the write side
    task automatic rd_cycle(input logic clr, input logic stp, input logic drv);
        rd_clear = clr;
        rd_step  = stp;
        rd_drive = drv;
        #3 rclk = 1'b1;
        #3 rclk = 1'b0;
    endtask
endmodule // sff_video_model

// ### tb/tb_dual_port_serial_field_fifo.sv
// Self-checking bench for the serial field FIFO top.
// Assumes the video model drives both ports; clk_sys only feeds status flags.
module tb_dual_port_serial_field_fifo import sff_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk_sys = 1'b0;
    logic              resetn  = 1'b0;
    int                error_cnt = 0;
    int                tests_run = 0;
    logic [31:0]       seed = 32'h00000053;
    logic [DATA_W-1:0] exp_mem [int];
    wire               wclk, wclr, wen, wmsk, rclk, rclr, rstp, rdrv;
    wire  [DATA_W-1:0] wdat, rbus;
    wire               roe, wshort, rshort;
    always #4 clk_sys = ~clk_sys;
    sff_video_model video (.wclk(wclk), .wr_clear(wclr), .wr_en(wen), .wr_mask(wmsk), .wr_data(wdat),
        .rclk(rclk), .rd_clear(rclr), .rd_step(rstp), .rd_drive(rdrv));
    sff_top dut (.clk_sys(clk_sys), .resetn(resetn), .write_shift_clock(wclk), .write_pointer_clear(wclr),
        .write_enable(wen), .input_write_mask(wmsk), .input_byte_bus(wdat), .outbound_shift_clock(rclk),
        .outbound_pointer_clear(rclr), .outbound_step_gate(rstp), .output_drive_enable(rdrv),
        .output_byte_bus(rbus), .output_byte_oe(roe), .write_pass_short(wshort), .read_pass_short(rshort));
    // Fixed-seed xorshift source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        tests_run++;
        if (seen !== want) begin
            error_cnt++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Write pass from a clear; enable and mask set high in the clear cycle must do nothing
    task automatic wr_pass(input int n, input bit rnd_mask);
        logic [31:0] r;
        int          ptr;
        ptr = 0;
        video.wr_cycle(1'b1, 1'b1, 1'b1, 8'hA5);
        while (ptr < n) begin
            r = xs();
            if (r[2:0] == 3'h0) begin
                video.wr_cycle(1'b0, 1'b0, 1'b1, r[15:8]);
            end else begin
                video.wr_cycle(1'b0, 1'b1, ~rnd_mask | r[4], r[15:8]);
                if (~rnd_mask | r[4]) exp_mem[ptr] = r[15:8];
                ptr++;
            end
        end
    endtask
    // Read pass from a clear; step and drive levels in the clear cycle must do nothing
    task automatic rd_pass(input int n, input bit chk);
        logic [31:0]       r;
        int                ptr;
        logic              oe_was;
        logic [DATA_W-1:0] last;
        ptr = 0;
        oe_was = roe;
        video.rd_cycle(1'b1, 1'b1, ~oe_was);
        if (chk) check({7'h00, roe}, {7'h00, oe_was});
        while (ptr < n) begin
            r = xs();
            if (ptr == 0) r[2:0] = 3'h7; // First word always driven and stepped
            video.rd_cycle(1'b0, r[1:0] != 2'h0, r[2]);
            if (chk) check({7'h00, roe}, {7'h00, r[2]});
            if (r[1:0] != 2'h0) begin
                if (chk && roe === 1'b1) check(rbus, exp_mem[ptr]);
                last = rbus;
                ptr++;
            end else if (chk && roe === 1'b1 && ptr > 0) begin
                check(rbus, last);
            end
        end
    endtask
    // Flags settle within five system clocks of a clear
    task automatic flags(input logic wf, input logic rf);
        repeat (6) @(posedge clk_sys);
        check({7'h00, wshort}, {7'h00, wf});
        check({7'h00, rshort}, {7'h00, rf});
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
    initial begin
        // Both shift clocks run during reset so each port sees it
        fork
            begin
                repeat (16) @(posedge clk_sys);
                resetn <= 1'b1;
            end
            repeat (20) video.wr_cycle(1'b0, 1'b0, 1'b0, 8'h00);
            repeat (20) video.rd_cycle(1'b0, 1'b0, 1'b0);
        join
        check(rbus, 8'h00);
        check({7'h00, roe}, 8'h00);
        @(posedge clk_sys);
        repeat (80) video.wr_cycle(1'b0, 1'b0, 1'b0, 8'h00);
        repeat (80) video.rd_cycle(1'b0, 1'b0, 1'b0);
        wr_pass(120, 1'b0);
        wr_pass(120, 1'b1);
        video.wr_cycle(1'b1, 1'b0, 1'b0, 8'h00);
        repeat (2) video.wr_cycle(1'b0, 1'b0, 1'b0, 8'h00);
        repeat (600) video.rd_cycle(1'b0, 1'b0, 1'b0);
        // Unchecked pass only once the store holds data; unwritten flops read as unknown
        rd_pass(90, 1'b0);
        rd_pass(110, 1'b1);
        flags(1'b0, 1'b0);
        // Deliberately short passes on each port raise the sticky flags
        wr_pass(10, 1'b0);
        video.wr_cycle(1'b1, 1'b0, 1'b0, 8'h00);
        flags(1'b1, 1'b0);
        rd_pass(5, 1'b0);
        video.rd_cycle(1'b1, 1'b0, 1'b0);
        flags(1'b1, 1'b1);
        conclude();
    end
endmodule // tb_dual_port_serial_field_fifo
